// ==== verilog/pgb_port_b_io.sv ====
// The register addresses and register access over AXI4-Lite are this design's own decisions.
`include "pgb_params.svh"

module pgb_port_b_io
	import pgb_pkg::*;
(
	// Clock and resets
	input  wire logic        I_MCLK,
	input  wire logic        I_RST,
	input  wire logic        I_EXT_RST,
	// AXI4-Lite write address and data
	input  wire logic [7:0]  S_AXI_AWADDR,
	input  wire logic        S_AXI_AWVALID,
	output logic             S_AXI_AWREADY,
	input  wire logic [31:0] S_AXI_WDATA,
	input  wire logic [3:0]  S_AXI_WSTRB,
	input  wire logic        S_AXI_WVALID,
	output logic             S_AXI_WREADY,
	// AXI4-Lite write response
	output logic [1:0]       S_AXI_BRESP,
	output logic             S_AXI_BVALID,
	input  wire logic        S_AXI_BREADY,
	// AXI4-Lite read
	input  wire logic [7:0]  S_AXI_ARADDR,
	input  wire logic        S_AXI_ARVALID,
	output logic             S_AXI_ARREADY,
	output logic [31:0]      S_AXI_RDATA,
	output logic [1:0]       S_AXI_RRESP,
	output logic             S_AXI_RVALID,
	input  wire logic        S_AXI_RREADY,
	// Port B pads
	input  wire logic [7:0]  I_PORT_B_PIN,
	output pgb_pad_s         O_PORT_B_PAD,
	output logic [7:0]       O_PORT_B_PULLUP,
	// First port inputs
	input  wire logic [7:0]  I_PORT_A_PIN,
	input  wire logic [7:0]  I_PORT_A_ANALOG,
	input  wire logic        I_PORT_A_EXT_RST_MODE,
	// Core side
	output logic             O_CHANGE_IRQ,
	output logic             O_WAKE
);

	// ****************************************
	// Registers and decode
	// ****************************************
	logic [7:0]  b_out_q, b_dir_q, b_pu_q, b_an_q;
	logic [7:0]  a_chg_en_q, b_chg_en_q;
	logic        chg_ie_q, chg_flag_q, glob_pu_q;
	pgb_pins_s   last_q;
	pgb_pins_s   cur;
	logic [7:0]  aw_addr_q;
	logic [7:0]  a_live, b_live, a_diff, b_diff;
	logic        aw_have_q, w_have_q;
	logic [31:0] w_data_q;
	logic [3:0]  w_strb_q;
	logic        wr_go, rd_go, port_access, mismatch;
	logic [31:0] rd_word;
	logic        rd_ok;

	// Both port words reload the compare latch
	function automatic logic is_port(input logic [7:0] a);
		is_port = (a == `PGB_OFS_B_DATA) || (a == `PGB_OFS_A_DATA);
	endfunction

	// Unmapped words answer with an error
	function automatic logic is_mapped(input logic [7:0] a);
		case (a)
			`PGB_OFS_B_DATA, `PGB_OFS_B_DIR, `PGB_OFS_B_PULLUP, `PGB_OFS_B_ANALOG,
			`PGB_OFS_A_DATA, `PGB_OFS_A_CHG_EN, `PGB_OFS_B_CHG_EN,
			`PGB_OFS_INT_CTRL, `PGB_OFS_OPTION: is_mapped = 1'b1;
			default: is_mapped = 1'b0;
		endcase
	endfunction

	// ****************************************
	// Write channel
	// ****************************************
	// BVALID holds both readies low so a new write cannot pass its response
	assign S_AXI_AWREADY = !aw_have_q && !S_AXI_BVALID;
	assign S_AXI_WREADY  = !w_have_q && !S_AXI_BVALID;
	assign wr_go         = aw_have_q && w_have_q && !S_AXI_BVALID;

	always_ff @(posedge I_MCLK or posedge I_RST) begin
		if (I_RST) begin
			aw_have_q <= 1'b0;
			aw_addr_q <= 8'h00;
		end else if (S_AXI_AWVALID && S_AXI_AWREADY) begin
			aw_have_q <= 1'b1;
			aw_addr_q <= {S_AXI_AWADDR[7:2], 2'h0};
		end else if (wr_go) begin
			aw_have_q <= 1'b0;
		end
	end

	always_ff @(posedge I_MCLK or posedge I_RST) begin
		if (I_RST) begin
			w_have_q <= 1'b0;
			w_data_q <= 32'h0000_0000;
			w_strb_q <= 4'h0;
		end else if (S_AXI_WVALID && S_AXI_WREADY) begin
			w_have_q <= 1'b1;
			w_data_q <= S_AXI_WDATA;
			w_strb_q <= S_AXI_WSTRB;
		end else if (wr_go) begin
			w_have_q <= 1'b0;
		end
	end

	always_ff @(posedge I_MCLK or posedge I_RST) begin
		if (I_RST) begin
			S_AXI_BVALID <= 1'b0;
			S_AXI_BRESP  <= `PGB_RESP_OKAY;
		end else if (wr_go) begin
			// A miss still answers, with an error, so the master never hangs
			S_AXI_BVALID <= 1'b1;
			S_AXI_BRESP  <= is_mapped(aw_addr_q) ? `PGB_RESP_OKAY : `PGB_RESP_SLVERR;
		end else if (S_AXI_BREADY) begin
			S_AXI_BVALID <= 1'b0;
		end
	end

	// ****************************************
	// Register file
	// ****************************************
	// Only the low byte lane carries register data
	logic wr_en;
	assign wr_en = wr_go && w_strb_q[0];

	// Unimplemented bits are masked on the way in, so they always read zero
	function automatic logic wr_hit(input logic en, input logic [7:0] a, input logic [7:0] o);
		wr_hit = en && (a == o);
	endfunction

	// External reset restores configuration except the change enables, and not the compare latch
	// write to latch
	always_ff @(posedge I_MCLK or posedge I_RST) begin
		if (I_RST) begin
			b_out_q <= `PGB_RST_B_DATA;
		end else if (I_EXT_RST) begin
			b_out_q <= `PGB_RST_B_DATA;
		end else if (wr_hit(wr_en, aw_addr_q, `PGB_OFS_B_DATA)) begin
			b_out_q <= w_data_q[7:0] & `PGB_B_IO_MASK;
		end
	end

	always_ff @(posedge I_MCLK or posedge I_RST) begin
		if (I_RST) begin
			b_dir_q <= `PGB_RST_B_DIR;
		end else if (I_EXT_RST) begin
			b_dir_q <= `PGB_RST_B_DIR;
		end else if (wr_hit(wr_en, aw_addr_q, `PGB_OFS_B_DIR)) begin
			b_dir_q <= w_data_q[7:0] & `PGB_B_IO_MASK;
		end
	end

	always_ff @(posedge I_MCLK or posedge I_RST) begin
		if (I_RST) begin
			b_pu_q <= `PGB_RST_B_PULLUP;
		end else if (I_EXT_RST) begin
			b_pu_q <= `PGB_RST_B_PULLUP;
		end else if (wr_hit(wr_en, aw_addr_q, `PGB_OFS_B_PULLUP)) begin
			b_pu_q <= w_data_q[7:0] & `PGB_B_PULLUP_MASK;
		end
	end

	always_ff @(posedge I_MCLK or posedge I_RST) begin
		if (I_RST) begin
			b_an_q <= `PGB_RST_B_ANALOG;
		end else if (I_EXT_RST) begin
			b_an_q <= `PGB_RST_B_ANALOG;
		end else if (wr_hit(wr_en, aw_addr_q, `PGB_OFS_B_ANALOG)) begin
			b_an_q <= w_data_q[7:0] & `PGB_B_ANALOG_MASK;
		end
	end

	always_ff @(posedge I_MCLK or posedge I_RST) begin
		if (I_RST) begin
			glob_pu_q <= 1'b0;
		end else if (I_EXT_RST) begin
			glob_pu_q <= 1'b0;
		end else if (wr_hit(wr_en, aw_addr_q, `PGB_OFS_OPTION)) begin
			glob_pu_q <= w_data_q[`PGB_GLOBAL_PU_BIT];
		end
	end

	// Change-interrupt enable
	always_ff @(posedge I_MCLK or posedge I_RST) begin
		if (I_RST) begin
			chg_ie_q <= 1'b0;
		end else if (I_EXT_RST) begin
			chg_ie_q <= 1'b0;
		end else if (wr_hit(wr_en, aw_addr_q, `PGB_OFS_INT_CTRL)) begin
			chg_ie_q <= w_data_q[`PGB_INT_ENABLE_BIT];
		end
	end

	// enables cleared by power-on reset only
	always_ff @(posedge I_MCLK or posedge I_RST) begin
		if (I_RST) begin
			a_chg_en_q <= `PGB_RST_CHG_EN;
		end else if (wr_hit(wr_en, aw_addr_q, `PGB_OFS_A_CHG_EN)) begin
			a_chg_en_q <= w_data_q[7:0] & `PGB_A_IO_MASK;
		end
	end

	always_ff @(posedge I_MCLK or posedge I_RST) begin
		if (I_RST) begin
			b_chg_en_q <= `PGB_RST_CHG_EN;
		end else if (wr_hit(wr_en, aw_addr_q, `PGB_OFS_B_CHG_EN)) begin
			b_chg_en_q <= w_data_q[7:0] & `PGB_B_IO_MASK;
		end
	end

	// ****************************************
	// Pads and pull-ups
	// ****************************************
	// Missing pins are never driven
	// driver enabled when direction is 0
	assign O_PORT_B_PAD.oe   = ~b_dir_q & `PGB_B_IO_MASK &
		~(8'h01 << `PGB_B_OPEN_DRAIN & b_out_q);
	// Open-drain pin only ever pulls low
	assign O_PORT_B_PAD.dout = b_out_q & ~(8'h01 << `PGB_B_OPEN_DRAIN);

	genvar gi;
	generate
		for (gi = 0; gi < 8; gi++) begin : g_pu
			assign O_PORT_B_PULLUP[gi] = glob_pu_q && b_dir_q[gi] && b_pu_q[gi] &&
				!b_an_q[gi];
		end
	endgenerate

	// ****************************************
	// Change detection
	// ****************************************
	// analog pins read 0 and drop out of detection
	assign cur.port_b = I_PORT_B_PIN & ~b_an_q & `PGB_B_IO_MASK;
	assign cur.port_a = I_PORT_A_PIN & ~I_PORT_A_ANALOG & `PGB_A_IO_MASK;

	// any read or write of either port reloads the latch
	assign port_access = (rd_go && is_port(S_AXI_ARADDR & 8'hFC)) ||
		(wr_go && is_port(aw_addr_q));

	// A read and a write in one cycle load the same pin values
	// kept through external reset
	always_ff @(posedge I_MCLK or posedge I_RST) begin
		if (I_RST) begin
			last_q <= '0;
		end else if (port_access) begin
			last_q <= cur;
		end
	end

	// analog pins drop out of detection
	// input-only pin off in external reset mode
	assign b_live = b_chg_en_q & ~b_an_q;
	assign a_live = a_chg_en_q & ~I_PORT_A_ANALOG &
		~({7'h00, I_PORT_A_EXT_RST_MODE} << `PGB_A_INPUT_ONLY);

	genvar gj;
	generate
		for (gj = 0; gj < 8; gj++) begin : g_diff
			assign b_diff[gj] = b_live[gj] && (cur.port_b[gj] != last_q.port_b[gj]);
			assign a_diff[gj] = a_live[gj] && (cur.port_a[gj] != last_q.port_a[gj]);
		end
	endgenerate

	// a change in an access cycle is compared with the old latch only
	assign mismatch = (|b_diff) || (|a_diff);

	// ****************************************
	// Change flag
	// ****************************************

	// set wins over a software clear
	always_ff @(posedge I_MCLK or posedge I_RST) begin
		if (I_RST) begin
			chg_flag_q <= 1'b0;
		end else if (mismatch) begin
			chg_flag_q <= 1'b1;
		end else if (I_EXT_RST) begin
			chg_flag_q <= 1'b0;
		end else if (wr_en && aw_addr_q == `PGB_OFS_INT_CTRL) begin
			chg_flag_q <= w_data_q[`PGB_INT_FLAG_BIT];
		end
	end

	// ****************************************
	// Interrupt outputs
	// ****************************************
	// request gated by change-interrupt enable
	assign O_CHANGE_IRQ = chg_flag_q && chg_ie_q;
	// The core decides when to sleep; this level only asks it to resume
	// wake from sleep
	assign O_WAKE       = chg_flag_q && chg_ie_q;

	// ****************************************
	// Read channel
	// ****************************************
	// One read in flight: the address is refused while its answer stands
	assign S_AXI_ARREADY = !S_AXI_RVALID;
	assign rd_go         = S_AXI_ARVALID && S_AXI_ARREADY;

	always_comb begin
		rd_word = 32'h0000_0000;
		rd_ok   = 1'b1;
		case (S_AXI_ARADDR & 8'hFC)
			// pin levels, not the output latch
			`PGB_OFS_B_DATA:   rd_word[7:0] = cur.port_b;
			`PGB_OFS_B_DIR:    rd_word[7:0] = b_dir_q;
			`PGB_OFS_B_PULLUP: rd_word[7:0] = b_pu_q;
			`PGB_OFS_B_ANALOG: rd_word[7:0] = b_an_q;
			`PGB_OFS_A_DATA:   rd_word[7:0] = cur.port_a;
			`PGB_OFS_A_CHG_EN: rd_word[7:0] = a_chg_en_q;
			`PGB_OFS_B_CHG_EN: rd_word[7:0] = b_chg_en_q;
			`PGB_OFS_INT_CTRL: begin
				rd_word[`PGB_INT_ENABLE_BIT] = chg_ie_q;
				rd_word[`PGB_INT_FLAG_BIT]   = chg_flag_q;
			end
			`PGB_OFS_OPTION:   rd_word[`PGB_GLOBAL_PU_BIT] = glob_pu_q;
			default:           rd_ok = 1'b0;
		endcase
	end

	always_ff @(posedge I_MCLK or posedge I_RST) begin
		if (I_RST) begin
			S_AXI_RVALID <= 1'b0;
			S_AXI_RDATA  <= 32'h0000_0000;
			S_AXI_RRESP  <= `PGB_RESP_OKAY;
		end else if (rd_go) begin
			// Data is captured here so it stands unchanged until taken
			S_AXI_RVALID <= 1'b1;
			S_AXI_RDATA  <= rd_word;
			S_AXI_RRESP  <= rd_ok ? `PGB_RESP_OKAY : `PGB_RESP_SLVERR;
		end else if (S_AXI_RREADY) begin
			S_AXI_RVALID <= 1'b0;
		end
	end

endmodule // pgb_port_b_io

// ==== verilog/pgb_params.svh ====
`ifndef PGB_PARAMS_SVH
`define PGB_PARAMS_SVH

// Byte offsets of the register words
`define PGB_OFS_B_DATA      8'h00
`define PGB_OFS_B_DIR       8'h04
`define PGB_OFS_B_PULLUP    8'h08
`define PGB_OFS_B_ANALOG    8'h0C
`define PGB_OFS_A_DATA      8'h10
`define PGB_OFS_A_CHG_EN    8'h14
`define PGB_OFS_B_CHG_EN    8'h18
`define PGB_OFS_INT_CTRL    8'h1C
`define PGB_OFS_OPTION      8'h20

// Implemented bit masks and the open-drain bit
`define PGB_B_IO_MASK       8'hF3
`define PGB_B_PULLUP_MASK   8'hF2
`define PGB_B_ANALOG_MASK   8'h72
`define PGB_A_IO_MASK       8'hEF
`define PGB_B_OPEN_DRAIN    0

// Field positions
`define PGB_INT_FLAG_BIT    0
`define PGB_INT_ENABLE_BIT  3
`define PGB_A_INPUT_ONLY    5
`define PGB_GLOBAL_PU_BIT   7

// Reset values
`define PGB_RST_B_DATA      8'h00
`define PGB_RST_B_DIR       8'hF3
`define PGB_RST_B_PULLUP    8'hF2
`define PGB_RST_B_ANALOG    8'h72
`define PGB_RST_CHG_EN      8'h00

// Bus answers
`define PGB_RESP_OKAY       2'h0
`define PGB_RESP_SLVERR     2'h2

`endif

// ==== verilog/pgb_pkg.sv ====
package pgb_pkg;

	// Port B pad drive: data and output enable per pin
	typedef struct packed {
		logic [7:0] dout;
		logic [7:0] oe;
	} pgb_pad_s;

	// Change-detect view of both ports
	typedef struct packed {
		logic [7:0] port_a;
		logic [7:0] port_b;
	} pgb_pins_s;

endpackage

// ==== tb/pgb_pin_model.sv ====
module pgb_pin_model
	import pgb_pkg::*;
(
	// Pad side
	input  wire pgb_pad_s   i_pad,
	input  wire logic [7:0] i_pullup,
	// Far side drive
	input  wire logic [7:0] i_ext,
	input  wire logic       i_ext_en,
	output logic [7:0]      o_pin
);
	timeunit 1ns;
	timeprecision 1ns;
	// ****
	// Pin level
	// ****
	// driver, source, pull
	// A floating pin shows the inverse so a stale value cannot pass
	always_comb begin
		for (int i = 0; i < 8; i++) begin
			o_pin[i] = i_pad.oe[i] ? i_pad.dout[i] :
				i_ext_en ? i_ext[i] : i_pullup[i] | ~i_ext[i];
		end
	end
endmodule // pgb_pin_model

// ==== tb/pgb_chk_asserts.sv ====
`include "pgb_params.svh"

module pgb_chk_asserts
	import pgb_pkg::*;
(
	// Clock and reset
	input wire logic        I_MCLK,
	input wire logic        I_RST,
	// Bus
	input wire logic [7:0]  S_AXI_ARADDR,
	input wire logic        S_AXI_ARVALID,
	input wire logic        S_AXI_ARREADY,
	input wire logic [31:0] S_AXI_RDATA,
	input wire logic        S_AXI_RVALID,
	input wire logic        S_AXI_RREADY,
	input wire logic        S_AXI_BVALID,
	input wire logic        S_AXI_BREADY,
	// Pads and core
	input wire pgb_pad_s    O_PORT_B_PAD,
	input wire logic [7:0]  O_PORT_B_PULLUP,
	input wire logic        O_CHANGE_IRQ,
	input wire logic        O_WAKE
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] ra_q;
	default clocking @(posedge I_MCLK); endclocking
	default disable iff (I_RST);
	// ****
	// Checks
	// ****
	always_ff @(posedge I_MCLK or posedge I_RST) begin
		if (I_RST) ra_q <= 8'h00;
		else if (S_AXI_ARVALID && S_AXI_ARREADY) ra_q <= S_AXI_ARADDR;
	end
	a_wake_irq: assert property (O_WAKE == O_CHANGE_IRQ)
		else $error("wake differs from irq");
	a_por_quiet: assert property ($past(I_RST) |-> O_PORT_B_PULLUP == 8'h00 && !O_CHANGE_IRQ)
		else $error("pull-up or irq on after reset");
	a_pull_input: assert property ((O_PORT_B_PULLUP & O_PORT_B_PAD.oe) == 8'h00)
		else $error("pull-up on driven pin");
	a_pull_mask: assert property ((O_PORT_B_PULLUP & ~`PGB_B_PULLUP_MASK) == 8'h00)
		else $error("pull-up on missing bit");
	a_od_low: assert property (O_PORT_B_PAD.oe[0] |-> !O_PORT_B_PAD.dout[0])
		else $error("bit0 drives high");
	a_rd_answer: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID)
		else $error("no read answer");
	a_rd_once: assert property (S_AXI_RVALID && S_AXI_RREADY |=> !S_AXI_RVALID)
		else $error("read answer repeated");
	a_b_done: assert property (S_AXI_BVALID && S_AXI_BREADY |=> !S_AXI_BVALID)
		else $error("write answer repeated");
	a_rd_unimpl: assert property (S_AXI_RVALID && ra_q < 8'h0C
		|-> S_AXI_RDATA[3:2] == 2'h0 && S_AXI_RDATA[31:8] == 24'h0)
		else $error("missing bits read nonzero");
	c_irq: cover property ($rose(O_CHANGE_IRQ));
	c_wr: cover property (S_AXI_BVALID && S_AXI_BREADY);
	c_rd: cover property (S_AXI_RVALID && S_AXI_RREADY);
endmodule // pgb_chk_asserts

bind pgb_port_b_io pgb_chk_asserts i_chk (.I_MCLK, .I_RST, .S_AXI_ARADDR, .S_AXI_ARVALID,
	.S_AXI_ARREADY, .S_AXI_RDATA, .S_AXI_RVALID, .S_AXI_RREADY, .S_AXI_BVALID,
	.S_AXI_BREADY, .O_PORT_B_PAD, .O_PORT_B_PULLUP, .O_CHANGE_IRQ, .O_WAKE);

// ==== tb/test_port_b_io_change_interrupt.sv ====
module test_port_b_io_change_interrupt
	import pgb_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic        mclk, rst, ext_rst, aw_v, w_v, b_rdy, ar_v, r_rdy, pa_mode, ext_en;
	logic        aw_rdy, w_rdy, b_v, ar_rdy, r_v, irq, wake;
	logic [7:0]  aw_addr, ar_addr, pins, pull, pa_pin, pa_an, ext, r;
	logic [31:0] w_data, r_data;
	logic [1:0]  b_resp, r_resp;
	pgb_pad_s    pad;
	logic [33:0] exp_q[$];
	int          error_cnt, n_compared, cyc, seed;
	logic [7:0]  ofs[5] = '{8'h04, 8'h08, 8'h0C, 8'h14, 8'h18};
	logic [7:0]  msk[5] = '{8'hF3, 8'hF2, 8'h72, 8'hEF, 8'hF3};
	// ****
	// Harness
	// ****
	pgb_port_b_io i_dut (.I_MCLK(mclk), .I_RST(rst), .I_EXT_RST(ext_rst),
		.S_AXI_AWADDR(aw_addr), .S_AXI_AWVALID(aw_v), .S_AXI_AWREADY(aw_rdy),
		.S_AXI_WDATA(w_data), .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(w_v), .S_AXI_WREADY(w_rdy),
		.S_AXI_BRESP(b_resp), .S_AXI_BVALID(b_v), .S_AXI_BREADY(b_rdy),
		.S_AXI_ARADDR(ar_addr), .S_AXI_ARVALID(ar_v), .S_AXI_ARREADY(ar_rdy),
		.S_AXI_RDATA(r_data), .S_AXI_RRESP(r_resp), .S_AXI_RVALID(r_v), .S_AXI_RREADY(r_rdy),
		.I_PORT_B_PIN(pins), .O_PORT_B_PAD(pad), .O_PORT_B_PULLUP(pull),
		.I_PORT_A_PIN(pa_pin), .I_PORT_A_ANALOG(pa_an), .I_PORT_A_EXT_RST_MODE(pa_mode),
		.O_CHANGE_IRQ(irq), .O_WAKE(wake));
	pgb_pin_model i_pins (.i_pad(pad), .i_pullup(pull), .i_ext(ext), .i_ext_en(ext_en),
		.o_pin(pins));
	initial begin
		mclk = 1'b0;
		forever #50 mclk = ~mclk;
	end
	task automatic chk(input logic [33:0] seen, input logic [33:0] exp);
		n_compared++;
		if (seen !== exp) begin
			error_cnt++;
			$display("ERROR %0t seen %h exp %h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e = 2'h0);
		exp_q.push_back({e, 32'h0});
		@(posedge mclk);
		aw_addr <= a;
		w_data <= d;
		aw_v <= 1'b1;
		w_v <= 1'b1;
		b_rdy <= 1'b1;
		do begin
			@(posedge mclk);
			if (aw_rdy) aw_v <= 1'b0;
			if (w_rdy) w_v <= 1'b0;
		end while (!b_v);
		b_rdy <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e = 2'h0);
		exp_q.push_back({e, d});
		@(posedge mclk);
		ar_addr <= a;
		ar_v <= 1'b1;
		r_rdy <= 1'b1;
		do begin
			@(posedge mclk);
			if (ar_rdy) ar_v <= 1'b0;
		end while (!r_v);
		r_rdy <= 1'b0;
	endtask
	task automatic print_verdict;
		if (error_cnt == 0 && n_compared > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	always @(posedge mclk) begin
		if ((b_v && b_rdy) || (r_v && r_rdy))
			chk(b_v ? {b_resp, 32'h0} : {r_resp, r_data}, exp_q.pop_front());
		cyc++;
		if (cyc == 5000) begin
			error_cnt++;
			print_verdict();
		end
	end
	// ****
	// Scenarios
	// ****
	initial begin
		seed = 81396;
		{rst, ext_rst, aw_v, w_v, b_rdy, ar_v, r_rdy, pa_mode, ext_en} = 9'h101;
		{aw_addr, ar_addr, ext, pa_pin, pa_an} = 40'h0;
		w_data = 32'h0;
		repeat (5) @(posedge mclk);
		rst <= 1'b0;
		rd(8'h00, 32'h0);
		rd(8'h04, 32'hF3);
		rd(8'h08, 32'hF2);
		rd(8'h0C, 32'h72);
		rd(8'h18, 32'h0);
		rd(8'h20, 32'h0);
		foreach (ofs[i]) begin
			r = 8'($random(seed));
			wr(ofs[i], {24'h0, r});
			rd(ofs[i], {24'h0, r & msk[i]});
		end
		wr(8'h40, 32'hFF, 2'h2);
		rd(8'h40, 32'h0, 2'h2);
		wr(8'h0C, 32'h0);
		wr(8'h04, 32'hF3);
		wr(8'h20, 32'h0);
		r = 8'($random(seed));
		ext <= r;
		rd(8'h00, {24'h0, r & 8'hF3});
		wr(8'h0C, 32'h72);
		rd(8'h00, {24'h0, r & 8'h81});
		wr(8'h0C, 32'h0);
		ext <= 8'hFF;
		wr(8'h00, 32'hA5);
		wr(8'h04, 32'h0);
		rd(8'h00, 32'hA1);
		wr(8'h00, 32'h5A);
		rd(8'h00, 32'h52);
		chk({26'h0, pad.oe & 8'hF3}, 34'hF3);
		wr(8'h04, 32'hF3);
		wr(8'h08, 32'hF2);
		wr(8'h20, 32'h80);
		chk({26'h0, pull}, 34'hF2);
		ext_en <= 1'b0;
		rd(8'h00, 32'hF2);
		wr(8'h0C, 32'h72);
		chk({26'h0, pull}, 34'h80);
		rd(8'h00, 32'h80);
		wr(8'h0C, 32'h0);
		wr(8'h04, 32'h0F);
		chk({26'h0, pull}, 34'h02);
		wr(8'h20, 32'h0);
		chk({26'h0, pull}, 34'h0);
		ext_en <= 1'b1;
		ext <= 8'h00;
		wr(8'h04, 32'hF3);
		wr(8'h14, 32'h0);
		wr(8'h18, 32'h80);
		rd(8'h00, 32'h0);
		wr(8'h1C, 32'h08);
		ext <= 8'h01;
		repeat (3) @(posedge mclk);
		rd(8'h1C, 32'h08);
		ext <= 8'h81;
		repeat (3) @(posedge mclk);
		chk({33'h0, irq}, 34'h1);
		chk({33'h0, wake}, 34'h1);
		rd(8'h1C, 32'h09);
		wr(8'h1C, 32'h08);
		rd(8'h1C, 32'h09);
		rd(8'h00, 32'h81);
		wr(8'h1C, 32'h08);
		rd(8'h1C, 32'h08);
		wr(8'h1C, 32'h0);
		ext <= 8'h01;
		repeat (3) @(posedge mclk);
		rd(8'h1C, 32'h01);
		chk({33'h0, irq}, 34'h0);
		ext_rst <= 1'b1;
		@(posedge mclk);
		ext_rst <= 1'b0;
		repeat (2) @(posedge mclk);
		rd(8'h1C, 32'h01);
		rd(8'h18, 32'h80);
		wr(8'h18, 32'h82);
		rd(8'h00, 32'h01);
		wr(8'h1C, 32'h0);
		ext <= 8'h03;
		repeat (3) @(posedge mclk);
		rd(8'h1C, 32'h0);
		wr(8'h14, 32'h20);
		rd(8'h10, 32'h0);
		pa_mode <= 1'b1;
		pa_pin <= 8'h20;
		repeat (3) @(posedge mclk);
		rd(8'h1C, 32'h0);
		pa_mode <= 1'b0;
		repeat (3) @(posedge mclk);
		rd(8'h1C, 32'h01);
		rd(8'h10, 32'h20);
		pa_an <= 8'h20;
		wr(8'h1C, 32'h0);
		rd(8'h1C, 32'h0);
		rd(8'h10, 32'h0);
		print_verdict();
	end
endmodule // test_port_b_io_change_interrupt
